// ### bench/bsc_ctrl_model.sv
`timescale 1ns/10ps
// Test controller driving the serial port, clock still outside frames
module bsc_ctrl_model import bsc_pkg::*; (
    // Serial port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // Idle levels before the first frame
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One clock of 125 ns: lines set while low, tdo sampled at rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        o = tdo;
        #62.5 tck = 1'b0;
    endtask : step
    // Five highs park the controller, then one low to idle
    task automatic to_idle();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        tdi = ~tdi;
    endtask : to_idle
    // Full scan of n bits, LSB first, idle to idle
    task automatic scan(input logic ir, input logic [BSR_MAX-1:0] din,
                        input int n, output logic [BSR_MAX-1:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        // Second high selects the instruction side
        if (ir) begin
            step(1'b1, 1'b0, o);
        end
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        // Exactly n shifts, last one leaves shift
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], o);
            dout[k] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        // Released data line shows the inverse of its last bit
        tdi = ~din[n-1];
    endtask : scan
endmodule : bsc_ctrl_model

// ### bench/test_boundary_scan_tap.sv
`timescale 1ns/10ps
// Self-checking bench for the test access port
module test_boundary_scan_tap import bsc_pkg::*; ;
    localparam int N = BSR_MIN / CELLS_PER_PIN;
    logic ref_clk, reset_n, tck, tms, tdi, tdo, tdo_oe;
    logic config_busy, cfg_byte_valid;
    logic [CFG_W-1:0] cfg_byte;
    logic [N-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
    logic [N-1:0] keep_en, pad_keep, cap, po;
    logic [WORD_W-1:0] probe_in;
    logic [BSR_MAX-1:0] din, dout;
    int error_cnt, checked;
    int oe_cnt = 0;
    // Shift cycles seen with the data output enabled
    always @(posedge tck) begin
        if (tdo_oe === 1'b1) begin
            oe_cnt++;
        end
    end
    // Device and far-side controller
    bsc_tap #(.BSR_LEN(BSR_MIN)) bsc_tap_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .config_busy(config_busy), .cfg_byte(cfg_byte),
        .cfg_byte_valid(cfg_byte_valid), .core_out(core_out),
        .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .keep_en(keep_en),
        .pad_keep(pad_keep), .probe_in(probe_in));
    bsc_ctrl_model bsc_ctrl_model_inst (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo));
    // System clock, 100 ns
    always #50 ref_clk = ~ref_clk;
    // Compare and count
    task automatic chk(input string nm, input logic [BSR_MAX-1:0] e,
                       input logic [BSR_MAX-1:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wait_ref(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : wait_ref
    // Instruction load, checking the captured pattern
    task automatic load_ir(input bsc_ir_t op);
        bsc_tap_inst_scan(1'b1, BSR_MAX'(op), IR_W);
        chk("ir capture", IR_CAPTURE, dout[IR_W-1:0]);
        wait_ref(6);
    endtask : load_ir
    task automatic bsc_tap_inst_scan(input logic ir,
                                     input logic [BSR_MAX-1:0] d,
                                     input int n);
        bsc_ctrl_model_inst.scan(ir, d, n, dout);
    endtask : bsc_tap_inst_scan
    // Identification word after reset, then five-high reset
    task automatic t_ident();
        int oe_base;
        oe_base = oe_cnt;
        bsc_tap_inst_scan(1'b0, '0, WORD_W);
        chk("idcode", {4'h3, 16'h5A5A, 11'h2B3, 1'b1}, dout[31:0]);
        chk("tdo_oe shifts", WORD_W, oe_cnt - oe_base);
        chk("tdo_oe idle", 1'b0, tdo_oe);
        load_ir(OP_USERCODE);
        bsc_tap_inst_scan(1'b0, '0, WORD_W);
        chk("usercode", 32'hFFFF_FFFF, dout[31:0]);
        bsc_ctrl_model_inst.to_idle();
        bsc_tap_inst_scan(1'b0, '0, WORD_W);
        chk("idcode after reset", 32'h35A5_A567, dout[31:0]);
        $display("test ident done");
    endtask : t_ident
    // One-bit path for bypass, unknown code, floating and clamp
    task automatic t_bypass();
        bsc_ir_t ops [4] = '{OP_BYPASS, 10'h3A5, OP_HIGHZ, OP_CLAMP};
        foreach (ops[i]) begin
            load_ir(ops[i]);
            bsc_tap_inst_scan(1'b0, 8'hB4, 8);
            chk("bypass delay", 8'h68, dout[7:0]);
        end
        $display("test bypass done");
    endtask : t_bypass
    // Sample, preload, external test, clamp and float on the pads
    task automatic t_pins();
        @(posedge ref_clk);
        core_out <= {127{4'h3}};
        core_oe  <= '1;
        pad_in   <= {127{4'h9}};
        keep_en  <= {127{4'h6}};
        po = {127{4'hA}};
        din = '0;
        for (int i = 0; i < N; i++) begin
            din[3*i+1] = po[i];
            din[3*i+2] = 1'b1;
        end
        load_ir(OP_SAMPLE);
        bsc_tap_inst_scan(1'b0, din, BSR_MIN);
        for (int i = 0; i < N; i++) cap[i] = dout[3*i];
        chk("sample capture", pad_in, cap);
        chk("sample pads", core_out, pad_out);
        chk("core in", pad_in, core_in);
        load_ir(OP_EXTEST);
        chk("extest out", po, pad_out);
        chk("extest oe", {N{1'b1}}, pad_oe);
        bsc_tap_inst_scan(1'b0, din, BSR_MIN);
        for (int i = 0; i < N; i++) cap[i] = dout[3*i];
        chk("extest capture", pad_in, cap);
        load_ir(OP_CLAMP);
        chk("clamp out", po, pad_out);
        load_ir(OP_HIGHZ);
        chk("highz oe", {N{1'b0}}, pad_oe);
        chk("keeper", keep_en, pad_keep);
        $display("test pins done");
    endtask : t_pins
    // Pin tests refused while configuration runs
    task automatic t_busy();
        @(posedge ref_clk);
        config_busy <= 1'b1;
        wait_ref(4);
        load_ir(OP_EXTEST);
        chk("busy pads", core_out, pad_out);
        chk("busy oe", core_oe, pad_oe);
        bsc_tap_inst_scan(1'b0, 8'hB4, 8);
        chk("busy bypass", 8'h68, dout[7:0]);
        @(posedge ref_clk);
        config_busy <= 1'b0;
        $display("test busy done");
    endtask : t_busy
    // Configuration byte stream and analyzer probe
    task automatic t_cfg_mon();
        int seen;
        seen = 0;
        load_ir(OP_CFG_LOAD);
        fork
            bsc_tap_inst_scan(1'b0, 8'hA5, 8);
            for (int k = 0; k < 200 && seen == 0; k++) begin
                @(negedge ref_clk);
                if (cfg_byte_valid === 1'b1) seen = 1;
            end
        join
        chk("cfg valid", 1'b1, seen[0]);
        chk("cfg byte", 8'hA5, cfg_byte);
        @(posedge ref_clk);
        probe_in <= 32'hC33C_5AA5;
        load_ir(OP_MONITOR);
        bsc_tap_inst_scan(1'b0, '0, WORD_W);
        chk("monitor", 32'hC33C_5AA5, dout[31:0]);
        $display("test config and monitor done");
    endtask : t_cfg_mon
    // Closing report
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // Main sequence
    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        config_busy = 1'b0;
        core_out = '0;
        core_oe = '0;
        pad_in = '0;
        keep_en = '0;
        probe_in = '0;
        error_cnt = 0;
        checked = 0;
        wait_ref(10);
        reset_n <= 1'b1;
        bsc_ctrl_model_inst.to_idle();
        t_ident();
        t_bypass();
        t_pins();
        t_busy();
        t_cfg_mon();
        give_verdict();
    end
endmodule : test_boundary_scan_tap

// ### src/bsc_chain.sv
`timescale 1ns/10ps
// Boundary cell chain with capture, shift and update stages
module bsc_chain import bsc_pkg::*; #(
    parameter int LEN = BSR_MIN
) (
    // Link clock and reset
    input  wire logic           tck,
    input  wire logic           reset_n,
    // Controls
    input  wire logic           tdi,
    input  wire logic           cap_en,
    input  wire logic           shift_en,
    input  wire logic           upd_en,
    // Parallel data
    input  wire logic [LEN-1:0] cap_data,
    output logic                sout,
    output logic      [LEN-1:0] upd_data
);

    logic [LEN-1:0] sh;         // Shift stage
    logic [LEN-1:0] next_sh;    // Next shift stage
    logic [LEN-1:0] next_upd;   // Next update stage

    // Capture, shift towards bit zero, or update
    always_comb begin
        next_sh  = sh;
        next_upd = upd_data;
        if (cap_en) begin
            next_sh = cap_data;
        end else if (shift_en) begin
            next_sh = {tdi, sh[LEN-1:1]};
        end
        if (upd_en) begin
            next_upd = sh;
        end
    end

    // Shift and update stages clear at reset; update zeros reach pins only in drive mode
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            sh       <= '0;
            upd_data <= '0;
        end else begin
            sh       <= next_sh;
            upd_data <= next_upd;
        end
    end

    assign sout = sh[0];

endmodule : bsc_chain

// ### src/bsc_pkg.sv
package bsc_pkg;

    // Register widths
    localparam int IR_W          = 10;
    localparam int WORD_W        = 32;
    localparam int CFG_W         = 8;
    localparam int CFG_CNT_W     = 3;
    // Boundary cells per pin and their order
    localparam int CELLS_PER_PIN = 3;
    localparam int CELL_IN       = 0;
    localparam int CELL_OUT      = 1;
    localparam int CELL_OE       = 2;
    // Legal boundary chain lengths
    localparam int BSR_MIN       = 1524;
    localparam int BSR_MAX       = 3228;
    // Identification word layout
    localparam int ID_VER_W      = 4;
    localparam int ID_PART_W     = 16;
    localparam int ID_MFR_W      = 11;

    typedef logic [IR_W-1:0] bsc_ir_t;

    // Instruction pattern loaded at capture
    localparam bsc_ir_t IR_CAPTURE   = 10'h001;
    // Opcodes
    localparam bsc_ir_t OP_EXTEST    = 10'h000;
    localparam bsc_ir_t OP_CFG_LOAD  = 10'h002;
    localparam bsc_ir_t OP_SAMPLE    = 10'h005;
    localparam bsc_ir_t OP_IDCODE    = 10'h006;
    localparam bsc_ir_t OP_USERCODE  = 10'h007;
    localparam bsc_ir_t OP_CLAMP     = 10'h00A;
    localparam bsc_ir_t OP_HIGHZ     = 10'h00B;
    localparam bsc_ir_t OP_MONITOR   = 10'h00E;
    localparam bsc_ir_t OP_BYPASS    = 10'h3FF;

    // Controller states
    typedef enum logic [3:0] {
        TS_RESET  = 4'h0, TS_IDLE   = 4'h1, TS_SEL_DR = 4'h2,
        TS_CAP_DR = 4'h3, TS_SH_DR  = 4'h4, TS_EX1_DR = 4'h5,
        TS_PA_DR  = 4'h6, TS_EX2_DR = 4'h7, TS_UP_DR  = 4'h8,
        TS_SEL_IR = 4'h9, TS_CAP_IR = 4'hA, TS_SH_IR  = 4'hB,
        TS_EX1_IR = 4'hC, TS_PA_IR  = 4'hD, TS_EX2_IR = 4'hE,
        TS_UP_IR  = 4'hF
    } bsc_tap_e;

    // Data path selected by the instruction
    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0, DR_BSR = 3'h1, DR_ID = 3'h2,
        DR_USER = 3'h3, DR_PROBE = 3'h4, DR_CFG = 3'h5
    } bsc_dr_e;

    // Pin ownership
    typedef enum logic [1:0] {
        PM_NORMAL = 2'h0, PM_DRIVE = 2'h1, PM_HIGHZ = 2'h2
    } bsc_pmode_e;

endpackage : bsc_pkg

// ### src/bsc_tap.sv
`timescale 1ns/10ps
module bsc_tap import bsc_pkg::*; #(
    parameter int                  BSR_LEN   = BSR_MIN,
    parameter int                  N_IO      = BSR_LEN / CELLS_PER_PIN,
    parameter logic [ID_VER_W-1:0]  ID_VER    = 4'h3,      // Arbitrary
    parameter logic [ID_PART_W-1:0] ID_PART   = 16'h5A5A,  // Arbitrary
    parameter logic [ID_MFR_W-1:0]  ID_MFR    = 11'h2B3,   // Arbitrary
    parameter logic [WORD_W-1:0]    USER_CODE = 32'hFFFF_FFFF
) (
    // System clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // Serial test port
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_oe,
    // Configuration status and byte stream
    input  wire logic              config_busy,
    output logic [CFG_W-1:0]       cfg_byte,
    output logic                   cfg_byte_valid,
    // Core side of the pins
    input  wire logic [N_IO-1:0]   core_out,
    input  wire logic [N_IO-1:0]   core_oe,
    output logic      [N_IO-1:0]   core_in,
    // Pads
    input  wire logic [N_IO-1:0]   pad_in,
    output logic      [N_IO-1:0]   pad_out,
    output logic      [N_IO-1:0]   pad_oe,
    input  wire logic [N_IO-1:0]   keep_en,
    output logic      [N_IO-1:0]   pad_keep,
    // Internal signals for the analyzer
    input  wire logic [WORD_W-1:0] probe_in
);

    // Refuse chain lengths the pin mapping cannot serve
    if (BSR_LEN < BSR_MIN || BSR_LEN > BSR_MAX ||
        N_IO * CELLS_PER_PIN != BSR_LEN) begin : g_len_check
        $error("bsc_tap: illegal boundary chain length");
    end

    localparam logic [WORD_W-1:0] ID_WORD =
        {ID_VER, ID_PART, ID_MFR, 1'b1};

    // ---------------- link domain ----------------
    bsc_tap_e     state, next_state;     // Controller state
    bsc_ir_t      ir_sh, next_ir_sh;     // Instruction shifter
    bsc_ir_t      ir, next_ir;           // Active instruction
    logic         busy_s1, busy_s2;      // Config busy synchroniser
    logic [N_IO-1:0] pin_s1, pin_s2;     // Pad input synchroniser
    logic [N_IO-1:0] pout_s1, pout_s2;   // Pad output synchroniser
    logic [N_IO-1:0] poe_s1, poe_s2;     // Pad enable synchroniser
    logic [WORD_W-1:0] prb_s1, prb_s2;   // Probe synchroniser
    bsc_dr_e      dr_sel;                // Selected data path
    logic         byp, next_byp;         // Bypass bit
    logic [WORD_W-1:0] dr_word, next_dr_word; // Id, user, probe word
    logic [CFG_W-1:0] cfg_sh, next_cfg_sh;    // Config assembler
    logic [CFG_CNT_W-1:0] cfg_cnt, next_cfg_cnt; // Bits assembled
    logic [CFG_W-1:0] cfg_hold, next_cfg_hold;   // Finished byte
    logic         cfg_tog, next_cfg_tog; // Byte ready toggle
    bsc_pmode_e   mode, next_mode;       // Requested pin mode
    logic         xfer_tog, next_xfer_tog; // Pin data ready toggle
    logic [BSR_LEN-1:0] bsr_cap;         // Chain capture values
    logic [BSR_LEN-1:0] bsr_upd;         // Chain update values
    logic         bsr_so;                // Chain serial out
    logic         bsr_sel;               // Chain is the data path

    // Controller and instruction register next values
    always_comb begin
        next_ir_sh = ir_sh;
        next_ir    = ir;
        unique case (state)
            TS_RESET:  next_ir    = OP_IDCODE;
            TS_CAP_IR: next_ir_sh = IR_CAPTURE;
            TS_SH_IR:  next_ir_sh = {tdi, ir_sh[IR_W-1:1]};
            TS_UP_IR:  next_ir    = ir_sh;
            default:   next_ir_sh = ir_sh;
        endcase
        unique case (state)
            TS_RESET:  next_state = tms ? TS_RESET  : TS_IDLE;
            TS_IDLE:   next_state = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: next_state = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: next_state = tms ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  next_state = tms ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: next_state = tms ? TS_UP_DR  : TS_PA_DR;
            TS_PA_DR:  next_state = tms ? TS_EX2_DR : TS_PA_DR;
            TS_EX2_DR: next_state = tms ? TS_UP_DR  : TS_SH_DR;
            TS_UP_DR:  next_state = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: next_state = tms ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: next_state = tms ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  next_state = tms ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: next_state = tms ? TS_UP_IR  : TS_PA_IR;
            TS_PA_IR:  next_state = tms ? TS_EX2_IR : TS_PA_IR;
            TS_EX2_IR: next_state = tms ? TS_UP_IR  : TS_SH_IR;
            TS_UP_IR:  next_state = tms ? TS_SEL_DR : TS_IDLE;
        endcase
    end

    // Controller registers
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            state <= TS_RESET;
            ir_sh <= IR_CAPTURE;
            ir    <= OP_IDCODE;
        end else begin
            state <= next_state;
            ir_sh <= next_ir_sh;
            ir    <= next_ir;
        end
    end

    // Synchronisers into the link domain
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            {busy_s1, busy_s2} <= 2'h0;
            {pin_s1, pin_s2}   <= '0;
            {pout_s1, pout_s2} <= '0;
            {poe_s1, poe_s2}   <= '0;
            {prb_s1, prb_s2}   <= '0;
        end else begin
            busy_s1 <= config_busy;
            busy_s2 <= busy_s1;
            pin_s1  <= pad_in;
            pin_s2  <= pin_s1;
            pout_s1 <= pad_out;
            pout_s2 <= pout_s1;
            poe_s1  <= pad_oe;
            poe_s2  <= poe_s1;
            prb_s1  <= probe_in;
            prb_s2  <= prb_s1;
        end
    end

    // Instruction decode; pin tests fall back to bypass when busy
    // Pin mode follows the incoming instruction so it lands at update
    always_comb begin
        unique case (ir)
            OP_EXTEST, OP_SAMPLE:
                dr_sel = busy_s2 ? DR_BYPASS : DR_BSR;
            OP_IDCODE:   dr_sel = DR_ID;
            OP_USERCODE: dr_sel = DR_USER;
            OP_MONITOR:  dr_sel = DR_PROBE;
            OP_CFG_LOAD: dr_sel = DR_CFG;
            default:     dr_sel = DR_BYPASS;
        endcase
        bsr_sel = (dr_sel == DR_BSR);
        unique case (next_ir)
            OP_EXTEST, OP_CLAMP: next_mode = PM_DRIVE;
            OP_HIGHZ:            next_mode = PM_HIGHZ;
            default:             next_mode = PM_NORMAL;
        endcase
        if (busy_s2) begin
            next_mode = PM_NORMAL;
        end
        next_xfer_tog = xfer_tog ^ ((next_mode != mode) ||
                        (bsr_sel && state == TS_UP_DR));
    end

    // Capture pin values, three cells per pin
    always_comb begin
        bsr_cap = '0;
        for (int i = 0; i < N_IO; i++) begin
            bsr_cap[i*CELLS_PER_PIN+CELL_IN]  = pin_s2[i];
            bsr_cap[i*CELLS_PER_PIN+CELL_OUT] = pout_s2[i];
            bsr_cap[i*CELLS_PER_PIN+CELL_OE]  = poe_s2[i];
        end
    end

    bsc_chain #(.LEN(BSR_LEN)) u_chain (
        .tck      (tck),
        .reset_n  (reset_n),
        .tdi      (tdi),
        .cap_en   (bsr_sel && state == TS_CAP_DR),
        .shift_en (bsr_sel && state == TS_SH_DR),
        .upd_en   (bsr_sel && state == TS_UP_DR),
        .cap_data (bsr_cap),
        .sout     (bsr_so),
        .upd_data (bsr_upd)
    );

    // Data registers next values
    always_comb begin
        next_byp      = byp;
        next_dr_word  = dr_word;
        next_cfg_sh   = cfg_sh;
        next_cfg_cnt  = cfg_cnt;
        next_cfg_hold = cfg_hold;
        next_cfg_tog  = cfg_tog;
        if (state == TS_CAP_DR) begin
            next_byp = 1'b0;
            unique case (dr_sel)
                DR_ID:    next_dr_word = ID_WORD;
                DR_USER:  next_dr_word = USER_CODE;
                DR_PROBE: next_dr_word = prb_s2;
                default:  next_dr_word = dr_word;
            endcase
        end else if (state == TS_SH_DR) begin
            next_byp     = tdi;
            next_dr_word = {tdi, dr_word[WORD_W-1:1]};
            if (dr_sel == DR_CFG) begin
                next_cfg_sh  = {tdi, cfg_sh[CFG_W-1:1]};
                next_cfg_cnt = cfg_cnt + 3'h1;
                if (cfg_cnt == 3'h7) begin
                    next_cfg_hold = next_cfg_sh;
                    next_cfg_tog  = ~cfg_tog;
                end
            end
        end
    end

    // Data registers
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            byp      <= 1'b0;
            dr_word  <= '0;
            cfg_sh   <= '0;
            cfg_cnt  <= '0;
            cfg_hold <= '0;
            cfg_tog  <= 1'b0;
            mode     <= PM_NORMAL;
            xfer_tog <= 1'b0;
        end else begin
            byp      <= next_byp;
            dr_word  <= next_dr_word;
            cfg_sh   <= next_cfg_sh;
            cfg_cnt  <= next_cfg_cnt;
            cfg_hold <= next_cfg_hold;
            cfg_tog  <= next_cfg_tog;
            mode     <= next_mode;
            xfer_tog <= next_xfer_tog;
        end
    end

    // Serial output changes on the falling link edge
    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo_oe <= (state == TS_SH_IR) || (state == TS_SH_DR);
            if (state == TS_SH_IR) begin
                tdo <= ir_sh[0];
            end else if (bsr_sel) begin
                tdo <= bsr_so;
            end else if (dr_sel inside {DR_ID, DR_USER, DR_PROBE}) begin
                tdo <= dr_word[0];
            end else begin
                tdo <= byp;
            end
        end
    end

    // ---------------- system domain ----------------
    logic [2:0] xfer_s;                  // Pin data toggle sync
    logic [2:0] cfg_s;                   // Config byte toggle sync
    logic [N_IO-1:0] pin_r1;             // First pad input flop
    bsc_pmode_e r_mode;                  // Pin mode in force
    logic [BSR_LEN-1:0] r_upd;           // Chain values in force
    logic [N_IO-1:0] r_upd_out, r_upd_oe; // Per-pin test values
    logic [N_IO-1:0] next_pad_out, next_pad_oe;

    // Pin multiplexing between core and test values
    always_comb begin
        for (int i = 0; i < N_IO; i++) begin
            r_upd_out[i] = r_upd[i*CELLS_PER_PIN+CELL_OUT];
            r_upd_oe[i]  = r_upd[i*CELLS_PER_PIN+CELL_OE];
        end
        next_pad_out = core_out;
        next_pad_oe  = core_oe;
        if (!config_busy && r_mode == PM_DRIVE) begin
            next_pad_out = r_upd_out;
            next_pad_oe  = r_upd_oe;
        end else if (!config_busy && r_mode == PM_HIGHZ) begin
            next_pad_oe  = '0;
        end
    end

    // Pin registers and crossings from the link domain
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            xfer_s         <= 3'h0;
            cfg_s          <= 3'h0;
            pin_r1         <= '0;
            core_in        <= '0;
            r_mode         <= PM_NORMAL;
            r_upd          <= '0;
            pad_out        <= '0;
            pad_oe         <= '0;
            pad_keep       <= '0;
            cfg_byte       <= '0;
            cfg_byte_valid <= 1'b0;
        end else begin
            xfer_s  <= {xfer_s[1:0], xfer_tog};
            cfg_s   <= {cfg_s[1:0], cfg_tog};
            pin_r1  <= pad_in;
            core_in <= pin_r1;
            if (xfer_s[2] != xfer_s[1]) begin
                r_mode <= mode;
                r_upd  <= bsr_upd;
            end
            pad_out  <= next_pad_out;
            pad_oe   <= next_pad_oe;
            pad_keep <= keep_en;
            cfg_byte_valid <= (cfg_s[2] != cfg_s[1]);
            if (cfg_s[2] != cfg_s[1]) begin
                cfg_byte <= cfg_hold;
            end
        end
    end

    // ---------------- checks ----------------
    sequence s_tms_high5;
        tms [*5];
    endsequence

    sequence s_ir_update;
        state == TS_UP_IR;
    endsequence

    a_five_highs: assert property (@(posedge tck) disable iff (!reset_n)
        s_tms_high5 |=> state == TS_RESET)
        else $error("five high tms did not reset the controller");
    a_ir_capture: assert property (@(posedge tck) disable iff (!reset_n)
        state == TS_CAP_IR |=> ir_sh == IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    a_ir_update: assert property (@(posedge tck) disable iff (!reset_n)
        s_ir_update |=> ir == $past(ir_sh))
        else $error("instruction not updated from shifter");
    a_bypass_delay: assert property (@(posedge tck) disable iff (!reset_n)
        (ir == OP_BYPASS && state == TS_SH_DR) |=> byp == $past(tdi))
        else $error("bypass bit did not take serial input");
    a_idcode_load: assert property (@(posedge tck) disable iff (!reset_n)
        (ir == OP_IDCODE && state == TS_CAP_DR) |=>
        (dr_word == ID_WORD && dr_word[0]))
        else $error("identification word not captured");
    a_user_load: assert property (@(posedge tck) disable iff (!reset_n)
        (ir == OP_USERCODE && state == TS_CAP_DR) |=> dr_word == USER_CODE)
        else $error("user code not captured");
    a_busy_normal: assert property (@(posedge tck) disable iff (!reset_n)
        busy_s2 |-> dr_sel != DR_BSR ##1 mode == PM_NORMAL)
        else $error("pin test allowed during configuration");
    a_clamp_path: assert property (@(posedge tck) disable iff (!reset_n)
        (ir == OP_CLAMP && !busy_s2) |->
        dr_sel == DR_BYPASS ##1 (mode == PM_DRIVE || $changed(ir)))
        else $error("clamp did not hold pins with bypass selected");
    a_highz_pins: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (r_mode == PM_HIGHZ && !config_busy) |=> pad_oe == '0)
        else $error("pins driven under high impedance mode");
    a_drive_pins: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (r_mode == PM_DRIVE && !config_busy) |=>
        (pad_out == $past(r_upd_out) && pad_oe == $past(r_upd_oe)))
        else $error("pins do not follow chain values");

endmodule : bsc_tap
